// ==== adc_seq_core.sv ====
// Sequencer and parallel host port of a four-channel converter.
// Assumes host pins are asynchronous and the sample bus is on i_mclk.
`timescale 1ns/10ps
`default_nettype none

module adc_seq_core (
   input  wire logic                              i_mclk,
   input  wire logic                              i_rst_n,
   input  wire logic                              i_conversion_trigger,
   input  wire logic                              i_cs_n,
   input  wire logic                              i_rd_n,
   input  wire logic                              i_wr_n,
   input  wire logic                              i_sw_select,
   input  wire logic                              i_use_ext_clock,
   input  wire logic                              i_low_power_hold,
   input  wire logic                              i_external_conv_clock,
   input  wire logic [adc_seq_pkg::SEL_W-1:0]     i_hw_select,
   input  wire logic [adc_seq_pkg::SEL_W-1:0]     i_low_data_lines,
   input  wire adc_seq_pkg::samples_t             i_samples,
   output var  adc_seq_pkg::dbus_t                o_db,
   output logic                                   o_busy,
   output logic                                   o_eoc_n,
   output logic                                   o_hold,
   output logic                                   o_first_result_flag
);

   localparam int A_CONV = adc_seq_pkg::CONV_CYC;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [2:0] popcount(input logic [3:0] m);
      popcount = 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
   endfunction

   function automatic logic [1:0] low_idx(input logic [3:0] m);
      low_idx = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
   endfunction

   // ----------------------------------------------------------------
   // Pin synchroniser and filter
   // ----------------------------------------------------------------
   logic [adc_seq_pkg::PIN_W-1:0] s1_r, s2_r, s3_r, flt_r, fd_r;
   logic [adc_seq_pkg::PIN_W-1:0] flt_nxt;
   adc_seq_pkg::pins_t            raw, p, pd;

   assign raw = '{conversion_trigger:  i_conversion_trigger,
                  cs_n:                i_cs_n,
                  rd_n:                i_rd_n,
                  wr_n:                i_wr_n,
                  sw_select:           i_sw_select,
                  use_ext_clock:       i_use_ext_clock,
                  low_power_hold:      i_low_power_hold,
                  external_conv_clock: i_external_conv_clock,
                  hw_select:           i_hw_select,
                  low_data_lines:      i_low_data_lines};
   assign p  = adc_seq_pkg::pins_t'(flt_r);
   assign pd = adc_seq_pkg::pins_t'(fd_r);

   // A bit moves only once stages two and three agree
   always_comb begin
      flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r ^ s3_r));
   end

   // Reset to idle pin levels so no false edge at release
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_r  <= 16'h7000;
         s2_r  <= 16'h7000;
         s3_r  <= 16'h7000;
         flt_r <= 16'h7000;
         fd_r  <= 16'h7000;
      end else begin
         s1_r  <= raw;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         flt_r <= flt_nxt;
         fd_r  <= flt_r;
      end
   end

   logic trig_rise, ext_edge, rd_act, rd_act_d, rd_end, wr_rise;
   logic [3:0] sel;

   assign trig_rise = p.conversion_trigger & ~pd.conversion_trigger;
   assign ext_edge  = p.external_conv_clock & ~pd.external_conv_clock;
   assign rd_act    = ~p.cs_n & ~p.rd_n;
   assign rd_act_d  = ~pd.cs_n & ~pd.rd_n;
   assign rd_end    = rd_act_d & ~rd_act;
   assign wr_rise   = p.wr_n & ~pd.wr_n & ~p.cs_n & p.rd_n;

   // ----------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------
   adc_seq_pkg::seq_state_t        state_r, state_nxt;
   logic [adc_seq_pkg::CNT_W-1:0]  cnt_r, cnt_nxt;
   logic [adc_seq_pkg::ECT_W-1:0]  ecnt_r, ecnt_nxt;
   logic [3:0]                     rem_r, rem_nxt;
   logic [1:0]                     slot_r, slot_nxt;
   logic [2:0]                     nsel_r, nsel_nxt;
   logic                           ext_r, ext_nxt;
   logic                           busy_r, busy_nxt;
   logic                           eoc_n_r, eoc_n_nxt;
   logic                           hold_r, hold_nxt;
   adc_seq_pkg::samples_t          held_r, held_nxt;
   logic [3:0]                     chsel_r;
   logic                           trig_ok, conv_done, mem_we;
   logic [adc_seq_pkg::DW-1:0]     mem_rdata;
   logic [1:0]                     ptr_r;

   assign sel = p.sw_select ? chsel_r : p.hw_select;
   // Standby or empty selection ignores the trigger
   assign trig_ok = trig_rise & p.low_power_hold & (sel != 4'h0)
                  & (state_r == adc_seq_pkg::S_IDLE);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      ecnt_nxt  = ecnt_r;
      rem_nxt   = rem_r;
      slot_nxt  = slot_r;
      nsel_nxt  = nsel_r;
      ext_nxt   = ext_r;
      busy_nxt  = busy_r;
      eoc_n_nxt = eoc_n_r;
      hold_nxt  = hold_r;
      held_nxt  = held_r;
      conv_done = 1'b0;
      mem_we    = 1'b0;
      unique case (state_r)
         adc_seq_pkg::S_IDLE: begin
            if (trig_ok) begin
               state_nxt = adc_seq_pkg::S_CONV;
               rem_nxt   = sel;
               nsel_nxt  = popcount(sel);
               held_nxt  = i_samples;
               hold_nxt  = 1'b1;
               busy_nxt  = 1'b1;
               ext_nxt   = p.use_ext_clock;
               slot_nxt  = 2'h0;
               cnt_nxt   = '0;
               ecnt_nxt  = '0;
            end
         end
         adc_seq_pkg::S_CONV: begin
            cnt_nxt  = cnt_r + 9'h001;
            ecnt_nxt = ecnt_r + 4'(ext_edge);
            if (ext_r) begin
               conv_done = ext_edge &&
                  ecnt_r == 4'(adc_seq_pkg::EXT_CONV_EDGES - 1);
            end else begin
               conv_done =
                  cnt_r == 9'(adc_seq_pkg::CONV_CYC - 1);
            end
            if (conv_done) begin
               mem_we    = 1'b1;
               state_nxt = adc_seq_pkg::S_EOC;
               eoc_n_nxt = 1'b0;
               cnt_nxt   = '0;
               // Last channel: busy ends as its strobe starts
               if ((rem_r & (rem_r - 4'h1)) == 4'h0) begin
                  busy_nxt = 1'b0;
                  hold_nxt = 1'b0;
               end
            end
         end
         adc_seq_pkg::S_EOC: begin
            cnt_nxt = cnt_r + 9'h001;
            if (cnt_r == 9'(adc_seq_pkg::EOC_CYC - 1)) begin
               eoc_n_nxt = 1'b1;
               rem_nxt   = rem_r & (rem_r - 4'h1);
               slot_nxt  = slot_r + 2'h1;
               cnt_nxt   = '0;
               ecnt_nxt  = '0;
               state_nxt = busy_r ? adc_seq_pkg::S_CONV
                                  : adc_seq_pkg::S_IDLE;
            end
         end
         default: begin
            state_nxt = adc_seq_pkg::S_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= adc_seq_pkg::S_IDLE;
         cnt_r   <= '0;
         ecnt_r  <= '0;
         rem_r   <= 4'h0;
         slot_r  <= 2'h0;
         nsel_r  <= 3'h0;
         ext_r   <= 1'b0;
         busy_r  <= 1'b0;
         eoc_n_r <= 1'b1;
         hold_r  <= 1'b0;
         held_r  <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         ecnt_r  <= ecnt_nxt;
         rem_r   <= rem_nxt;
         slot_r  <= slot_nxt;
         nsel_r  <= nsel_nxt;
         ext_r   <= ext_nxt;
         busy_r  <= busy_nxt;
         eoc_n_r <= eoc_n_nxt;
         hold_r  <= hold_nxt;
         held_r  <= held_nxt;
      end
   end

   result_mem u_mem (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_we    (mem_we),
      .i_waddr (slot_r),
      .i_wdata (held_r[low_idx(rem_r)]),
      .i_raddr (ptr_r),
      .o_rdata (mem_rdata)
   );

   // ----------------------------------------------------------------
   // Host port
   // ----------------------------------------------------------------
   logic [1:0]                 ptr_nxt;
   logic [3:0]                 chsel_nxt;
   logic                       flag_r, flag_nxt;
   logic [adc_seq_pkg::DW-1:0] db_r, db_nxt;

   always_comb begin
      ptr_nxt   = ptr_r;
      flag_nxt  = flag_r;
      chsel_nxt = chsel_r;
      db_nxt    = mem_rdata;
      if (wr_rise) begin
         chsel_nxt = p.low_data_lines;
      end
      if (trig_ok) begin
         ptr_nxt  = 2'h0;
         flag_nxt = 1'b1;
      end else if (rd_end) begin
         ptr_nxt  = ({1'b0, ptr_r} + 3'h1 >= nsel_r) ? 2'h0
                                                    : ptr_r + 2'h1;
         flag_nxt = (ptr_nxt == 2'h0);
      end
      // A fresh result not yet read keeps the flag low
      if (conv_done) begin
         flag_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ptr_r   <= 2'h0;
         flag_r  <= 1'b0;
         chsel_r <= adc_seq_pkg::CHSEL_RST;
         db_r    <= '0;
      end else begin
         ptr_r   <= ptr_nxt;
         flag_r  <= flag_nxt;
         chsel_r <= chsel_nxt;
         db_r    <= db_nxt;
      end
   end

   // Enable straight from the filtered strobes to meet 30 ns release
   assign o_db                = '{data: db_r, oe: rd_act};
   assign o_busy              = busy_r;
   assign o_eoc_n             = eoc_n_r;
   assign o_hold              = hold_r;
   assign o_first_result_flag = flag_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Own cycle count, so a wrong end count in the sequencer shows
   logic [adc_seq_pkg::CNT_W-1:0] conv_age_r, conv_age_nxt;

   always_comb begin
      conv_age_nxt = (state_r == adc_seq_pkg::S_CONV) ? conv_age_r + 9'h001
                                                      : 9'h000;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         conv_age_r <= '0;
      end else begin
         conv_age_r <= conv_age_nxt;
      end
   end

   AST_INT_CONV_TIME: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      ($fell(o_eoc_n) && !ext_r) |->
      ($past(conv_age_r) == 9'(A_CONV - 1)))
      else $error("internal conversion length wrong");

   AST_EXT_CONV_EDGES: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      (state_r == adc_seq_pkg::S_CONV && ext_r && ext_edge &&
       ecnt_r == 4'(adc_seq_pkg::EXT_CONV_EDGES - 1)) |=>
      (state_r == adc_seq_pkg::S_EOC && !o_eoc_n))
      else $error("external conversion edge count wrong");

   AST_BUSY_END: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      $fell(o_busy) |-> $fell(o_eoc_n) && rem_r == (rem_r & -rem_r))
      else $error("busy did not end at last done strobe");

   AST_FLAG_READ: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      (rd_end && !conv_done && !trig_ok) |=>
      (o_first_result_flag == (ptr_r == 2'h0)))
      else $error("first flag not updated after read");

   AST_FLAG_EOC: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      $fell(o_eoc_n) |-> !o_first_result_flag)
      else $error("first flag high after done strobe fall");

   AST_RELEASE: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      (rd_act && !(~flt_nxt[13] & ~flt_nxt[14])) |=> !o_db.oe)
      else $error("data bus not released");

   AST_BUSY_RISE: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      trig_ok |=> o_busy && o_eoc_n && state_r == adc_seq_pkg::S_CONV)
      else $error("busy did not rise on trigger");

   AST_FLAG_PTR: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      o_first_result_flag |-> ptr_r == 2'h0)
      else $error("first flag high off first result");

   AST_WRITE_SEL: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      wr_rise |=> chsel_r == $past(p.low_data_lines))
      else $error("channel select not captured");

   AST_HOLD_LATCH: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      trig_ok |=> o_hold && rem_r == $past(sel) && held_r == $past(i_samples))
      else $error("trigger did not hold and latch");

endmodule

`default_nettype wire

// ==== adc_seq_pkg.sv ====
// Constants, pin bundles and states for the converter sequencer core.
// Assumes a single 200 MHz clock; all host pins arrive asynchronously.
package adc_seq_pkg;

   // -----------------------------------------------------------------
   // Sizes
   // -----------------------------------------------------------------
   localparam int NCH   = 4;
   localparam int DW    = 12;
   localparam int SEL_W = 4;
   localparam int PTR_W = 2;
   localparam int CNT_W = 9;
   localparam int ECT_W = 4;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   // Longest time, rounds down
   localparam int CONV_NS  = 1650;
   localparam int CONV_CYC = (CONV_NS * CLK_MHZ) / 1000;
   localparam int EXT_CONV_EDGES = 13;
   // Done strobe width, inside the 75..180 ns window
   localparam int EOC_NS  = 100;
   localparam int EOC_CYC = (EOC_NS * CLK_MHZ + 999) / 1000;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [SEL_W-1:0] CHSEL_RST = 4'hf;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic             conversion_trigger;
      logic             cs_n;
      logic             rd_n;
      logic             wr_n;
      logic             sw_select;
      logic             use_ext_clock;
      logic             low_power_hold;
      logic             external_conv_clock;
      logic [SEL_W-1:0] hw_select;
      logic [SEL_W-1:0] low_data_lines;
   } pins_t;

   localparam int PIN_W = $bits(pins_t);

   typedef logic [NCH-1:0][DW-1:0] samples_t;

   typedef struct packed {
      logic [DW-1:0] data;
      logic          oe;
   } dbus_t;

   typedef enum logic [1:0] {
      S_IDLE,
      S_CONV,
      S_EOC
   } seq_state_t;

endpackage

// ==== adc_sequence_timing_host_port_tb.sv ====
// Self-checking bench for the converter sequencer and its host port.
// Assumes adc_seq_pkg and host_port_model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module adc_sequence_timing_host_port_tb;
   logic                  i_mclk = 1'b0;
   logic                  i_rst_n = 1'b0;
   logic                  sw_sel = 1'b0;
   logic                  use_ext = 1'b0;
   logic                  ext_clk = 1'b0;
   logic [3:0]            hw_sel = 4'h0;
   adc_seq_pkg::samples_t smp = '0;
   adc_seq_pkg::dbus_t    o_db;
   logic                  o_busy;
   logic                  o_eoc_n;
   logic                  o_hold;
   logic                  o_first_result_flag;
   logic                  cs_n;
   logic                  rd_n;
   logic                  wr_n;
   logic [3:0]            dl;
   logic                  trig;
   logic                  lph;
   logic                  eoc_q = 1'b1;
   int                    error_cnt = 0;
   int                    compares = 0;
   int                    busy_cyc = 0;
   int                    eoc_falls = 0;
   int                    eoc_low = 0;

   initial forever #2.5 i_mclk = ~i_mclk;

   adc_seq_core DUT (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_conversion_trigger(trig),
      .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_sw_select(sw_sel),
      .i_use_ext_clock(use_ext), .i_low_power_hold(lph),
      .i_external_conv_clock(ext_clk), .i_hw_select(hw_sel),
      .i_low_data_lines(dl), .i_samples(smp), .o_db(o_db),
      .o_busy(o_busy), .o_eoc_n(o_eoc_n), .o_hold(o_hold),
      .o_first_result_flag(o_first_result_flag));

   host_port_model hm (
      .i_mclk(i_mclk), .i_busy(o_busy), .i_db(o_db), .o_cs_n(cs_n),
      .o_rd_n(rd_n), .o_wr_n(wr_n), .o_low_data_lines(dl),
      .o_conversion_trigger(trig), .o_low_power_hold(lph));

   task automatic tick();
      @(posedge i_mclk);
      #1;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
      end
   endtask

   task automatic results();
      if (error_cnt == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   function automatic int popc(input logic [3:0] m);
      popc = m[0] + m[1] + m[2] + m[3];
   endfunction

   // k-th result belongs to the k-th selected channel, ascending
   function automatic logic [11:0] exp_word(input logic [3:0] m, int k);
      int c;
      c = 0;
      exp_word = '0;
      for (int j = 0; j < 4; j++) begin
         if (m[j]) begin
            if (c == k) exp_word = smp[j];
            c++;
         end
      end
   endfunction

   // -----------------------------------------------------------------
   // Strobe monitor
   // -----------------------------------------------------------------
   // Samples settled values, half a cycle after the launch edge
   always @(negedge i_mclk) begin
      if (o_busy === 1'b1) busy_cyc++;
      if (eoc_q === 1'b1 && o_eoc_n === 1'b0) eoc_falls++;
      if (eoc_q === 1'b0 && o_eoc_n === 1'b1)
         chk(eoc_low >= 15 && eoc_low <= 36, 1'b1);
      if (o_eoc_n === 1'b0) eoc_low++;
      else eoc_low = 0;
      if (eoc_low == 3) chk(o_first_result_flag, 1'b0);
      eoc_q = o_eoc_n;
   end

   // External clock only runs inside a conversion
   task automatic ext_edges(input int e0, output int n);
      for (n = 0; n < 40 && eoc_falls == e0; n++) begin
         repeat (8) tick();
         ext_clk = 1'b1;
         repeat (8) tick();
         ext_clk = 1'b0;
      end
   endtask

   task automatic run(input logic [3:0] m, input bit ext, input bit retrig);
      int b0, e0, i, n, ed, rel;
      logic [11:0] d;
      n = popc(m);
      b0 = busy_cyc;
      e0 = eoc_falls;
      for (i = 0; i < 4; i++) smp[i] = 12'($urandom);
      hm.fire();
      for (i = 0; i < 14 && o_busy !== 1'b1; i++) tick();
      chk(o_busy, 1'b1);
      chk(o_hold, 1'b1);
      chk(o_first_result_flag, 1'b1);
      hm.fire_end();
      if (retrig) begin
         repeat (50) tick();
         hm.fire();
         hm.fire_end();
      end
      if (ext) begin
         ext_edges(e0, ed);
         chk(ed, 13);
      end
      for (i = 0; i < 3000 && o_busy !== 1'b0; i++) tick();
      // Last done strobe starts with busy falling; let the monitor see it
      tick();
      chk(o_busy, 1'b0);
      chk(o_hold, 1'b0);
      if (!ext) chk(busy_cyc - b0, n * (adc_seq_pkg::CONV_CYC
         + adc_seq_pkg::EOC_CYC) - adc_seq_pkg::EOC_CYC);
      chk(eoc_falls - e0, n);
      chk(o_first_result_flag, 1'b0);
      for (int k = 0; k < n; k++) begin
         hm.read(d, rel);
         chk(d, exp_word(m, k));
         chk(rel >= 2 && rel <= 6, 1'b1);
         chk(o_first_result_flag, (k + 1) == n);
      end
   endtask

   task automatic refuse();
      int b0;
      b0 = busy_cyc;
      hm.fire();
      repeat (14) tick();
      hm.fire_end();
      repeat (10) tick();
      chk(busy_cyc - b0, 0);
      chk(o_hold, 1'b0);
   endtask

   initial begin
      repeat (100000) @(posedge i_mclk);
      error_cnt++;
      results();
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      logic [3:0] msk;
      void'($urandom(3));
      repeat (4) @(posedge i_mclk);
      #1;
      i_rst_n = 1'b1;
      tick();
      chk(o_busy, 1'b0);
      chk(o_eoc_n, 1'b1);
      chk(o_db.oe, 1'b0);
      hm.wake();
      // Register reset selects all four; a retrigger must be ignored
      sw_sel = 1'b1;
      run(adc_seq_pkg::CHSEL_RST, 1'b0, 1'b1);
      for (int i = 0; i < 5; i++) begin
         msk = (i == 0) ? 4'h1 : (i == 1) ? 4'h8 : 4'(1 + $urandom % 15);
         sw_sel = 1'b0;
         hw_sel = msk;
         run(msk, 1'b0, 1'b0);
      end
      msk = 4'(1 + $urandom % 15);
      hm.write(msk);
      sw_sel = 1'b1;
      hw_sel = ~msk;
      run(msk, 1'b0, 1'b0);
      sw_sel = 1'b0;
      use_ext = 1'b1;
      hw_sel = 4'(4'h1 << ($urandom % 4));
      run(hw_sel, 1'b1, 1'b0);
      use_ext = 1'b0;
      hw_sel = 4'h0;
      refuse();
      hw_sel = 4'h3;
      hm.sleep();
      refuse();
      hm.wake();
      run(4'h3, 1'b0, 1'b0);
      results();
   end
endmodule
`default_nettype wire

// ==== host_port_model.sv ====
// Host side of the converter's parallel port: trigger, wake, read, write.
// Assumes one shared clock; pins change 1 ns after a rising edge.
`timescale 1ns/10ps
`default_nettype none

module host_port_model #(
   parameter int WAKE_CYC = 400
) (
   input  wire logic               i_mclk,
   input  wire logic               i_busy,
   input  wire adc_seq_pkg::dbus_t i_db,
   output var  logic               o_cs_n,
   output var  logic               o_rd_n,
   output var  logic               o_wr_n,
   output var  logic [3:0]         o_low_data_lines,
   output var  logic               o_conversion_trigger,
   output var  logic               o_low_power_hold
);
   initial begin
      o_cs_n = 1'b1;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_low_data_lines = 4'h0;
      o_conversion_trigger = 1'b0;
      o_low_power_hold = 1'b0;
   end

   task automatic tick();
      @(posedge i_mclk);
      #1;
   endtask

   // -----------------------------------------------------------------
   // Power and trigger
   // -----------------------------------------------------------------
   task automatic wake();
      o_low_power_hold = 1'b1;
      repeat (WAKE_CYC) tick();
   endtask

   task automatic sleep();
      o_low_power_hold = 1'b0;
      repeat (8) tick();
   endtask

   task automatic fire();
      o_conversion_trigger = 1'b1;
      tick();
   endtask

   // Keeps the pulse past 35 ns whatever the caller waited
   task automatic fire_end();
      repeat (8) tick();
      o_conversion_trigger = 1'b0;
      repeat (4) tick();
   endtask

   // -----------------------------------------------------------------
   // Bus cycles
   // -----------------------------------------------------------------
   task automatic write(input logic [3:0] v);
      o_cs_n = 1'b0;
      tick();
      o_low_data_lines = v;
      o_wr_n = 1'b0;
      repeat (6) tick();
      o_wr_n = 1'b1;
      repeat (6) tick();
      o_cs_n = 1'b1;
      // Released lines must not keep the last value
      o_low_data_lines = ~v;
      repeat (6) tick();
   endtask

   task automatic read(output logic [11:0] d, output int rel);
      int i;
      bit seen_oe;
      for (i = 0; i < 3000 && i_busy !== 1'b0; i++) tick();
      o_cs_n = 1'b0;
      o_rd_n = 1'b0;
      repeat (7) tick();
      seen_oe = (i_db.oe === 1'b1);
      d = i_db.data;
      tick();
      o_rd_n = 1'b1;
      o_cs_n = 1'b1;
      for (rel = 1; rel < 10; rel++) begin
         tick();
         if (i_db.oe === 1'b0) break;
      end
      // A stuck busy or an undriven bus both fail the caller's check
      if (i == 3000 || !seen_oe) rel = 0;
      // Spacing well above the filter's resolution
      repeat (14) tick();
   endtask
endmodule
`default_nettype wire

// ==== result_mem.sv ====
// Result store: one word per conversion slot, registered read.
// Assumes writer and reader share the core clock.
`timescale 1ns/10ps
`default_nettype none

module result_mem (
   input  wire logic                           i_mclk,
   input  wire logic                           i_rst_n,
   input  wire logic                           i_we,
   input  wire logic [adc_seq_pkg::PTR_W-1:0]  i_waddr,
   input  wire logic [adc_seq_pkg::DW-1:0]     i_wdata,
   input  wire logic [adc_seq_pkg::PTR_W-1:0]  i_raddr,
   output var  logic [adc_seq_pkg::DW-1:0]     o_rdata
);

   logic [adc_seq_pkg::DW-1:0] mem_r [adc_seq_pkg::NCH];

   // Array has no reset; only the read register does
   always_ff @(posedge i_mclk) begin
      if (i_we) begin
         mem_r[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= mem_r[i_raddr];
      end
   end

endmodule

`default_nettype wire
